// *** rtl/dmcr_pkg.sv ***
// mode-control register bank constants, field layout and carrier types
// assumes a 7-bit register index and an 8-bit data path from the serial control engine
package dmcr_pkg;
  // register indices
  localparam logic [6:0] IDX_LEFT_ATTEN  = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_FMT_EMPH    = 7'h12;
  localparam logic [6:0] IDX_OUT_FILT    = 7'h13;
  localparam logic [6:0] IDX_SYS_MODE    = 7'h14;
  localparam logic [6:0] IDX_ZERO_OUT    = 7'h15;
  localparam logic [6:0] IDX_ZERO_STAT   = 7'h16;
  // reset values
  localparam logic [7:0] RST_ATTEN    = 8'hFF;
  localparam logic [7:0] RST_FMT_EMPH = 8'h50;
  localparam logic [7:0] RST_OUT_FILT = 8'h00;
  localparam logic [7:0] RST_SYS_MODE = 8'h00;
  localparam logic [7:0] RST_ZERO_OUT = 8'h01;
  // writable bit masks, reserved bits read zero
  localparam logic [7:0] MSK_SYS_MODE = 8'h7F;
  localparam logic [7:0] MSK_ZERO_OUT = 8'h07;
  // highest attenuation code that means full mute
  localparam logic [7:0] ATTEN_MUTE_MAX = 8'h0E;
  // format/emphasis register fields
  localparam int B_LOAD = 7;
  localparam int B_FMT  = 4;
  localparam int B_DRATE = 2;
  localparam int B_DEMPH = 1;
  localparam int B_MUTE = 0;
  // output/filter register fields
  localparam int B_REV  = 7;
  localparam int B_ATS  = 5;
  localparam int B_OPE  = 4;
  localparam int B_ZOE  = 3;
  localparam int B_BYPASS_STEREO_SEL = 2;
  localparam int B_FLT  = 1;
  localparam int B_INZ  = 0;
  // system mode register fields
  localparam int B_SOFT_SYSTEM_RESET = 6;
  localparam int B_BITS = 5;
  localparam int B_BYP  = 4;
  localparam int B_SINGLE_CHANNEL_MODE = 3;
  localparam int B_SINGLE_CHANNEL_MODE_CHANNEL_SEL = 2;
  localparam int B_OS   = 0;
  // zero output register fields
  localparam int B_DZ   = 1;
  localparam int B_PCM_ZERO_OUT_EN = 0;

  // settings handed to the datapath
  typedef struct packed {
    logic [2:0] input_format_sel;
    logic [1:0] emphasis_rate_sel;
    logic       emphasis_enable;
    logic       soft_mute_en;
    logic [1:0] fir_perf_sel;
    logic       phase_invert;
    logic [1:0] atten_speed_sel;
    logic       converter_disable;
    logic       zero_pin_output_sel;
    logic       bypass_stereo_sel;
    logic       rolloff_sel;
    logic       infinite_zero_mute_en;
    logic       soft_system_reset;
    logic       bitstream_mode_en;
    logic       filter_bypass_en;
    logic       single_channel_mode;
    logic       single_channel_mode_channel_sel;
    logic [1:0] oversample_rate_sel;
    logic [1:0] fir_rate_sel;
    logic       pcm_zero_out_en;
    logic [1:0] bitstream_zero_out_en;
  } dmcr_ctrl_t;

  // one register access from the serial engine
  typedef struct packed {
    logic       stb;
    logic       wr;
    logic [6:0] idx;
    logic [7:0] wdata;
  } dmcr_acc_t;
endpackage : dmcr_pkg

// *** rtl/dmcr_regs.sv ***
// mode-control register bank of a stereo audio converter
// assumes the serial control engine runs on clk_i and presents one
// decoded register access per strobe; zero-detect comes from the datapath
// on the same clock
//
// Functional notes
// RULE1 - eight-bit attenuation per channel, resets 0 dB
// RULE2 - attenuation load bit, resets disabled
// RULE3 - three-bit input format, resets 24-bit I2S
// RULE4 - emphasis rate field and enable, reset off
// RULE5 - bitstream mode: rate field selects FIR performance
// RULE6 - bitstream mode: oversample field selects FIR rate
// RULE7 - soft mute bit, resets disabled
// RULE8 - phase reversal bit, resets normal
// RULE9 - two-bit attenuation speed, resets full rate
// RULE10 - converter operation bit, resets enabled
// RULE11 - shared pins: bitstream input or zero flags
// RULE12 - bypass single_channel_mode/stereo select, resets monaural
// RULE13 - rolloff select, resets sharp
// RULE14 - infinite-zero mute enable, resets disabled
// RULE15 - system reset control bit, resets normal
// RULE16 - bitstream interface enable, resets disabled
// RULE17 - internal filter bypass bit, resets filter on
// RULE18 - single_channel_mode mode and channel select, reset stereo/left
// RULE19 - oversampling rate field, resets 64 times
// RULE20 - PCM zero out on, bitstream zero out off
// RULE21 - read-only per-channel zero flags
// RULE22 - settings reachable only through serial control
// RULE23 - load bit low keeps applied attenuation
// RULE24 - codes 0 to 14 mean infinite attenuation
`timescale 1ns/1ps
`default_nettype none

module dmcr_regs
  import dmcr_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // register access from the serial control engine
  input  wire dmcr_acc_t  acc_i,
  output logic            acc_ack_o,
  output logic [7:0]      acc_rdata_o,
  // zero detection from the datapath
  input  wire logic [1:0] zero_det_i,
  // settings to the datapath
  output var dmcr_ctrl_t  ctrl_o,
  output logic [7:0]      left_atten_level_o,
  output logic [7:0]      right_atten_level_o,
  output logic            left_atten_mute_o,
  output logic            right_atten_mute_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // write strobe for one index
  function automatic logic wr_hit(input dmcr_acc_t a, input logic [6:0] idx);
    wr_hit = a.stb & a.wr & (a.idx == idx);
  endfunction : wr_hit

  // codes at or below the mute threshold give infinite attenuation
  function automatic logic atten_is_mute(input logic [7:0] code);
    atten_is_mute = (code <= ATTEN_MUTE_MAX);
  endfunction : atten_is_mute

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] left_atten_ff;
  logic [7:0] right_atten_ff;
  logic [7:0] fmt_emph_ff;
  logic [7:0] out_filt_ff;
  logic [7:0] sys_mode_ff;
  logic [7:0] zero_out_ff;
  logic [7:0] applied_left_ff;
  logic [7:0] applied_right_ff;
  logic       ack_ff;
  logic [7:0] rdata_ff;
  dmcr_ctrl_t ctrl_ff;
  logic       left_mute_ff;
  logic       right_mute_ff;
  logic [7:0] nxt_rdata;
  dmcr_ctrl_t nxt_ctrl;

  // RULE22 only serial writes
  // attenuation registers, read back as written
  // RULE1 attenuation storage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_atten_ff  <= RST_ATTEN;
      right_atten_ff <= RST_ATTEN;
    end else begin
      if (wr_hit(acc_i, IDX_LEFT_ATTEN)) begin
        left_atten_ff <= acc_i.wdata;
      end
      if (wr_hit(acc_i, IDX_RIGHT_ATTEN)) begin
        right_atten_ff <= acc_i.wdata;
      end
    end
  end

  // applied attenuation follows a write only while loading is enabled;
  // a write made while disabled is not replayed when loading turns on
  // RULE23 load gating
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      applied_left_ff  <= RST_ATTEN;
      applied_right_ff <= RST_ATTEN;
    end else begin
      if (wr_hit(acc_i, IDX_LEFT_ATTEN) && fmt_emph_ff[B_LOAD]) begin
        applied_left_ff <= acc_i.wdata;
      end
      if (wr_hit(acc_i, IDX_RIGHT_ATTEN) && fmt_emph_ff[B_LOAD]) begin
        applied_right_ff <= acc_i.wdata;
      end
    end
  end

  // mode registers; reserved bits are masked so they read zero
  // RULE2 RULE3 RULE4 RULE7 mode bytes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fmt_emph_ff <= RST_FMT_EMPH;
      out_filt_ff <= RST_OUT_FILT;
      sys_mode_ff <= RST_SYS_MODE;
      zero_out_ff <= RST_ZERO_OUT;
    end else begin
      if (wr_hit(acc_i, IDX_FMT_EMPH)) begin
        fmt_emph_ff <= acc_i.wdata;
      end
      if (wr_hit(acc_i, IDX_OUT_FILT)) begin
        out_filt_ff <= acc_i.wdata;
      end
      if (wr_hit(acc_i, IDX_SYS_MODE)) begin
        sys_mode_ff <= acc_i.wdata & MSK_SYS_MODE;
      end
      if (wr_hit(acc_i, IDX_ZERO_OUT)) begin
        zero_out_ff <= acc_i.wdata & MSK_ZERO_OUT;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  // unmapped indices read zero; status is live, never latched
  // RULE21 zero flags
  always_comb begin
    case (acc_i.idx)
      IDX_LEFT_ATTEN:  nxt_rdata = left_atten_ff;
      IDX_RIGHT_ATTEN: nxt_rdata = right_atten_ff;
      IDX_FMT_EMPH:    nxt_rdata = fmt_emph_ff;
      IDX_OUT_FILT:    nxt_rdata = out_filt_ff;
      IDX_SYS_MODE:    nxt_rdata = sys_mode_ff;
      IDX_ZERO_OUT:    nxt_rdata = zero_out_ff;
      IDX_ZERO_STAT:   nxt_rdata = {6'h00, zero_det_i};
      default:         nxt_rdata = 8'h00;
    endcase
  end

  // answer one cycle after any strobe; data only changes on reads
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ack_ff <= acc_i.stb;
      if (acc_i.stb && !acc_i.wr) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // settings decode
  // ----------------------------------------------------------------

  // bitstream mode reuses two fields for the analog FIR; the PCM
  // meaning is forced off there so the datapath never sees both
  always_comb begin
    nxt_ctrl = '0;
    // RULE3 format select
    nxt_ctrl.input_format_sel      = fmt_emph_ff[B_FMT +: 3];
    nxt_ctrl.emphasis_enable       = fmt_emph_ff[B_DEMPH];
    // RULE7 soft mute
    nxt_ctrl.soft_mute_en          = fmt_emph_ff[B_MUTE];
    // RULE8 phase reversal
    nxt_ctrl.phase_invert          = out_filt_ff[B_REV];
    // RULE9 speed select
    nxt_ctrl.atten_speed_sel       = out_filt_ff[B_ATS +: 2];
    // RULE10 converter control
    nxt_ctrl.converter_disable     = out_filt_ff[B_OPE];
    // RULE11 shared pin role
    nxt_ctrl.zero_pin_output_sel   = out_filt_ff[B_ZOE];
    // RULE12 bypass stereo
    nxt_ctrl.bypass_stereo_sel     = out_filt_ff[B_BYPASS_STEREO_SEL];
    // RULE13 rolloff select
    nxt_ctrl.rolloff_sel           = out_filt_ff[B_FLT];
    // RULE14 infinite-zero mute
    nxt_ctrl.infinite_zero_mute_en = out_filt_ff[B_INZ];
    // RULE15 system reset
    nxt_ctrl.soft_system_reset     = sys_mode_ff[B_SOFT_SYSTEM_RESET];
    // RULE16 bitstream enable
    nxt_ctrl.bitstream_mode_en     = sys_mode_ff[B_BITS];
    // RULE17 filter bypass
    nxt_ctrl.filter_bypass_en      = sys_mode_ff[B_BYP];
    // RULE18 single_channel_mode and channel
    nxt_ctrl.single_channel_mode   = sys_mode_ff[B_SINGLE_CHANNEL_MODE];
    nxt_ctrl.single_channel_mode_channel_sel      = sys_mode_ff[B_SINGLE_CHANNEL_MODE_CHANNEL_SEL];
    // RULE20 zero output enables
    nxt_ctrl.pcm_zero_out_en       = zero_out_ff[B_PCM_ZERO_OUT_EN];
    nxt_ctrl.bitstream_zero_out_en = zero_out_ff[B_DZ +: 2];
    if (sys_mode_ff[B_BITS]) begin
      // RULE5 FIR performance
      nxt_ctrl.fir_perf_sel = fmt_emph_ff[B_DRATE +: 2];
      // RULE6 FIR rate
      nxt_ctrl.fir_rate_sel = sys_mode_ff[B_OS +: 2];
    end else begin
      // RULE4 emphasis rate
      nxt_ctrl.emphasis_rate_sel   = fmt_emph_ff[B_DRATE +: 2];
      // RULE19 oversampling rate
      nxt_ctrl.oversample_rate_sel = sys_mode_ff[B_OS +: 2];
    end
  end

  // registered so every datapath setting leaves from a flop
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // RULE24 mute decode
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_mute_ff  <= 1'b0;
      right_mute_ff <= 1'b0;
    end else begin
      left_mute_ff  <= atten_is_mute(applied_left_ff);
      right_mute_ff <= atten_is_mute(applied_right_ff);
    end
  end

  // outputs
  assign acc_ack_o           = ack_ff;
  assign acc_rdata_o         = rdata_ff;
  assign ctrl_o              = ctrl_ff;
  assign left_atten_level_o  = applied_left_ff;
  assign right_atten_level_o = applied_right_ff;
  assign left_atten_mute_o   = left_mute_ff;
  assign right_atten_mute_o  = right_mute_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  property p_load_applies;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_hit(acc_i, IDX_LEFT_ATTEN) && fmt_emph_ff[B_LOAD])
      |=> (left_atten_level_o == $past(acc_i.wdata));
  endproperty
  a_load_applies: assert property (p_load_applies) // RULE1
    else $error("left attenuation not applied");

  property p_load_blocked;
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_hit(acc_i, IDX_RIGHT_ATTEN) && !fmt_emph_ff[B_LOAD])
      |=> $stable(right_atten_level_o);
  endproperty
  a_load_blocked: assert property (p_load_blocked) // RULE23
    else $error("attenuation changed while load disabled");

  property p_mute_code;
    @(posedge clk_i) disable iff (!nrst_i)
    ##1 (left_atten_mute_o == ($past(left_atten_level_o) <= ATTEN_MUTE_MAX));
  endproperty
  a_mute_code: assert property (p_mute_code) // RULE24
    else $error("mute decode wrong");

  property p_mute_code_right;
    @(posedge clk_i) disable iff (!nrst_i)
    ##1 (right_atten_mute_o == ($past(right_atten_level_o) <= ATTEN_MUTE_MAX));
  endproperty
  a_mute_code_right: assert property (p_mute_code_right) // RULE24
    else $error("right mute decode wrong");

  property p_zero_read;
    @(posedge clk_i) disable iff (!nrst_i)
    (acc_i.stb && !acc_i.wr && acc_i.idx == IDX_ZERO_STAT)
      |=> (acc_rdata_o == {6'h00, $past(zero_det_i)}) && acc_ack_o;
  endproperty
  a_zero_read: assert property (p_zero_read) // RULE21
    else $error("zero flags misread");

  property p_bits_remap;
    @(posedge clk_i) disable iff (!nrst_i)
    sys_mode_ff[B_BITS] |=> (ctrl_o.emphasis_rate_sel == 2'h0)
      && (ctrl_o.fir_perf_sel == $past(fmt_emph_ff[B_DRATE +: 2]));
  endproperty
  a_bits_remap: assert property (p_bits_remap) // RULE5
    else $error("bitstream remap of rate field wrong");

  property p_os_remap;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_hit(acc_i, IDX_SYS_MODE) ##1 !sys_mode_ff[B_BITS]
      |=> (ctrl_o.oversample_rate_sel == $past(acc_i.wdata[1:0], 2))
        && (ctrl_o.fir_rate_sel == 2'h0);
  endproperty
  a_os_remap: assert property (p_os_remap) // RULE19
    else $error("oversampling field not passed");

  // any read of the zero-output byte, so it needs no back-to-back traffic
  property p_reserved_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    (acc_i.stb && !acc_i.wr && acc_i.idx == IDX_ZERO_OUT)
      |=> (acc_rdata_o[7:3] == 5'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE20
    else $error("reserved bits read nonzero");

  property p_mode_path;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_hit(acc_i, IDX_OUT_FILT) |-> ##2
      (ctrl_o.phase_invert == $past(acc_i.wdata[B_REV], 2))
      && (ctrl_o.converter_disable == $past(acc_i.wdata[B_OPE], 2));
  endproperty
  a_mode_path: assert property (p_mode_path) // RULE8
    else $error("output control not passed to datapath");

  property p_unmapped;
    @(posedge clk_i) disable iff (!nrst_i)
    (acc_i.stb && !acc_i.wr && (acc_i.idx < IDX_LEFT_ATTEN
      || acc_i.idx > IDX_ZERO_STAT)) |=> (acc_rdata_o == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) // RULE22
    else $error("unmapped index read nonzero");

  // the answer is one pulse per strobe; a stuck ack would hide lost accesses
  property p_ack_pulse;
    @(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> (acc_ack_o == $past(acc_i.stb));
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) // RULE22
    else $error("access answer not one cycle after strobe");

  // format byte reaches the datapath two cycles after the write
  property p_fmt_path;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_hit(acc_i, IDX_FMT_EMPH) |-> ##2
      (ctrl_o.input_format_sel == $past(acc_i.wdata[B_FMT +: 3], 2))
      && (ctrl_o.emphasis_enable == $past(acc_i.wdata[B_DEMPH], 2))
      && (ctrl_o.soft_mute_en == $past(acc_i.wdata[B_MUTE], 2));
  endproperty
  a_fmt_path: assert property (p_fmt_path) // RULE3
    else $error("format byte not passed to datapath");

  // mode bits that keep their meaning in every input mode
  property p_sys_path;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_hit(acc_i, IDX_SYS_MODE) |-> ##2
      (ctrl_o.single_channel_mode == $past(acc_i.wdata[B_SINGLE_CHANNEL_MODE], 2))
      && (ctrl_o.single_channel_mode_channel_sel == $past(acc_i.wdata[B_SINGLE_CHANNEL_MODE_CHANNEL_SEL], 2))
      && (ctrl_o.filter_bypass_en == $past(acc_i.wdata[B_BYP], 2))
      && (ctrl_o.soft_system_reset == $past(acc_i.wdata[B_SOFT_SYSTEM_RESET], 2))
      && (ctrl_o.bitstream_mode_en == $past(acc_i.wdata[B_BITS], 2));
  endproperty
  a_sys_path: assert property (p_sys_path) // RULE18
    else $error("system mode byte not passed to datapath");

  // zero-output enables follow their byte
  property p_zero_out_path;
    @(posedge clk_i) disable iff (!nrst_i)
    wr_hit(acc_i, IDX_ZERO_OUT) |-> ##2
      (ctrl_o.pcm_zero_out_en == $past(acc_i.wdata[B_PCM_ZERO_OUT_EN], 2))
      && (ctrl_o.bitstream_zero_out_en == $past(acc_i.wdata[B_DZ +: 2], 2));
  endproperty
  a_zero_out_path: assert property (p_zero_out_path) // RULE20
    else $error("zero output enables not passed to datapath");

endmodule : dmcr_regs

`default_nettype wire

// *** dv/dmcr_host.sv ***
// host model: issues one register access per strobe on the access port
// assumes clk_i is the bank clock and the bank answers one cycle later
`timescale 1ns/1ps
`default_nettype none

module dmcr_host
  import dmcr_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // access port towards the bank
  output var dmcr_acc_t   acc_o,
  input  wire logic       ack_i,
  input  wire logic [7:0] rdata_i
);
  // --------------------------------
  // access sequencing
  // --------------------------------
  logic last_ack;

  initial begin
    acc_o    = '0;
    last_ack = 1'b0;
  end

  task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    acc_o <= '{stb: 1'b1, wr: w, idx: idx, wdata: d};
    @(posedge clk_i);
    // released qualifiers turn inverse so a stale value never matches by luck
    acc_o <= '{stb: 1'b0, wr: ~w, idx: ~idx, wdata: ~d};
    @(posedge clk_i);
    last_ack = ack_i;
    q        = rdata_i;
  endtask : xfer
endmodule : dmcr_host

`default_nettype wire

// *** dv/dac_mode_control_registers_tb.sv ***
// testbench of the mode-control register bank
// assumes the bank and the host model share one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none

module dac_mode_control_registers_tb
  import dmcr_pkg::*;
;
  // --------------------------------
  // clock, reset, wiring
  // --------------------------------
  logic       clk_i;
  logic       nrst_i;
  dmcr_acc_t  acc;
  logic       ack;
  logic [7:0] rdata;
  logic [1:0] zero_det;
  dmcr_ctrl_t ctrl;
  dmcr_ctrl_t e;
  logic [7:0] lvl_l;
  logic [7:0] lvl_r;
  logic       mute_l;
  logic       mute_r;
  int         fail_count;
  int         tests_run;
  int         cycles;

  initial begin
    clk_i      = 1'b0;
    nrst_i     = 1'b0;
    zero_det   = 2'h0;
    fail_count = 0;
    tests_run  = 0;
    cycles     = 0;
  end

  // 5 ns period
  always #2.5 clk_i = ~clk_i;

  dmcr_regs dut_u (
    .clk_i               (clk_i),
    .nrst_i              (nrst_i),
    .acc_i               (acc),
    .acc_ack_o           (ack),
    .acc_rdata_o         (rdata),
    .zero_det_i          (zero_det),
    .ctrl_o              (ctrl),
    .left_atten_level_o  (lvl_l),
    .right_atten_level_o (lvl_r),
    .left_atten_mute_o   (mute_l),
    .right_atten_mute_o  (mute_r)
  );

  dmcr_host host_u (
    .clk_i   (clk_i),
    .acc_o   (acc),
    .ack_i   (ack),
    .rdata_i (rdata)
  );

  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    logic [7:0] q;
    host_u.xfer(1'b1, i, d, q);
    chk(32'(host_u.last_ack), 32'h1);
  endtask : wr

  task automatic rd(input logic [6:0] i, input logic [7:0] x);
    logic [7:0] q;
    host_u.xfer(1'b0, i, 8'h00, q);
    chk(32'(host_u.last_ack), 32'h1);
    chk(32'(q), 32'(x));
  endtask : rd

  // lets registered settings land before they are looked at
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset();
    logic [7:0] rv [6];
    rv = '{RST_ATTEN, RST_ATTEN, RST_FMT_EMPH, RST_OUT_FILT, RST_SYS_MODE, RST_ZERO_OUT};
    for (int i = 0; i < 6; i++) begin
      rd(7'(IDX_LEFT_ATTEN + i), rv[i]);
    end
    e                  = '0;
    e.input_format_sel = 3'h5;
    e.pcm_zero_out_en  = 1'b1;
    chk(32'(ctrl), 32'(e));
    chk({16'h0, lvl_l, lvl_r}, 32'hFFFF);
    chk({30'h0, mute_l, mute_r}, 32'h0);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_fields();
    wr(IDX_FMT_EMPH, 8'h7F);
    wr(IDX_OUT_FILT, 8'hFF);
    wr(IDX_SYS_MODE, 8'h9F);
    wr(IDX_ZERO_OUT, 8'hFF);
    settle();
    e                   = '1;
    e.fir_perf_sel      = 2'h0;
    e.fir_rate_sel      = 2'h0;
    e.soft_system_reset = 1'b0;
    e.bitstream_mode_en = 1'b0;
    chk(32'(ctrl), 32'(e));
    rd(IDX_SYS_MODE, 8'h1F);
    rd(IDX_ZERO_OUT, 8'h07);
    wr(IDX_SYS_MODE, 8'h7F);
    settle();
    e.soft_system_reset   = 1'b1;
    e.bitstream_mode_en   = 1'b1;
    e.emphasis_rate_sel   = 2'h0;
    e.fir_perf_sel        = 2'h3;
    e.oversample_rate_sel = 2'h0;
    e.fir_rate_sel        = 2'h3;
    chk(32'(ctrl), 32'(e));
    $display("test field decode done");
  endtask : t_fields

  task automatic t_atten();
    wr(IDX_FMT_EMPH, 8'h00);
    wr(IDX_LEFT_ATTEN, 8'h05);
    settle();
    chk(32'(lvl_l), 32'hFF);
    rd(IDX_LEFT_ATTEN, 8'h05);
    wr(IDX_FMT_EMPH, 8'h80);
    settle();
    chk(32'(lvl_l), 32'hFF);
    wr(IDX_LEFT_ATTEN, ATTEN_MUTE_MAX);
    wr(IDX_RIGHT_ATTEN, 8'h0F);
    settle();
    chk({16'h0, lvl_l, lvl_r}, 32'h0E0F);
    chk({30'h0, mute_l, mute_r}, 32'h2);
    wr(IDX_FMT_EMPH, 8'h00);
    wr(IDX_LEFT_ATTEN, 8'hFF);
    wr(IDX_RIGHT_ATTEN, 8'hFF);
    settle();
    chk({16'h0, lvl_l, lvl_r}, 32'h0E0F);
    $display("test attenuation load done");
  endtask : t_atten

  task automatic t_zero();
    for (int z = 0; z < 4; z++) begin
      @(posedge clk_i);
      zero_det <= 2'(z);
      rd(IDX_ZERO_STAT, 8'(z));
    end
    wr(IDX_ZERO_STAT, 8'h00);
    rd(IDX_ZERO_STAT, 8'h03);
    rd(7'h17, 8'h00);
    rd(7'h30, 8'h00);
    $display("test zero flags done");
  endtask : t_zero

  // --------------------------------
  // main sequence and hang guard
  // --------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_fields();
    t_atten();
    t_zero();
    finish_test();
  end

  // about 120 cycles of traffic expected, ceiling well above
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end
endmodule : dac_mode_control_registers_tb

`default_nettype wire
